// ### core/pwr_clk_pkg.sv
// Package with register map, field layout and types for the power saving clock manager
package pwr_clk_pkg;

  // Register offsets on the plain register port
  localparam logic [3:0] OSC_CTRL_OFS   = 4'h0;  // Oscillator control register
  localparam logic [3:0] CLK_DIV_OFS    = 4'h1;  // Clock divider register
  localparam logic [3:0] PERIPH_DIS_OFS = 4'h2;  // Peripheral disable bits
  localparam logic [3:0] PM_CTRL_OFS    = 4'h3;  // Power manager control
  localparam logic [3:0] PM_STAT_OFS    = 4'h4;  // Power manager status

  // Field positions
  localparam int NEW_OSC_LSB   = 8;   // New oscillator select bits 10:8
  localparam int CUR_OSC_LSB   = 12;  // Current oscillator bits 14:12
  localparam int SLOW_EN_BIT   = 11;  // Slowdown enable
  localparam int SLOW_RAT_LSB  = 12;  // Slowdown ratio bits 14:12
  localparam int RESTORE_BIT   = 15;  // Restore on interrupt
  localparam int DOG_EN_BIT    = 0;   // Control: watchdog enable
  localparam int CFM_EN_BIT    = 1;   // Control: clock failure monitor enable
  localparam int LOCK_BIT      = 2;   // Control: clock configuration lock

  // Widths and reset values
  localparam int NUM_PERIPH               = 16;
  localparam logic [15:0] PERIPH_PRESENT  = 16'hFFFF;  // Peripherals present in this variant
  localparam logic [15:0] CLK_DIV_RST     = 16'h0000;  // Ratio 1:1, slowdown off
  localparam logic [2:0]  OSC_SEL_RST     = 3'h0;
  localparam logic [15:0] PM_CTRL_RST     = 16'h0000;

  // Power-save instruction operands
  localparam logic PS_OP_SLEEP = 1'b0;
  localparam logic PS_OP_IDLE  = 1'b1;

  // Operating modes
  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_SLEEP,
    MODE_IDLE
  } pm_mode_t;

  // Register port request
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  // Request from the processor core
  typedef struct packed {
    logic ps_exec;  // Power-save instruction executes this cycle
    logic ps_op;    // Operand: sleep or idle
  } ps_req_t;

  // Clock enables and oscillator controls
  typedef struct packed {
    logic                  sys_clk_en;
    logic                  cpu_clk_en;
    logic [NUM_PERIPH-1:0] periph_clk_en;
    logic                  sys_osc_on;
    logic                  rc_osc_on;
    logic                  cfm_active;
    logic                  watchdog_clear;
  } clk_ctrl_t;

endpackage : pwr_clk_pkg

// ### core/power_saving_clock_manager.sv
// Power saving clock manager: sleep, idle, CPU slowdown and peripheral clock disable
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps

// Function
// - Sleep operand stops system clock and halts all execution.
// - Idle operand halts CPU; peripherals keep running on system clock.
// - Sleep shuts the system clock source and on-chip oscillator off.
// - Clock failure monitor is inactive during Sleep.
// - Low-power RC oscillator runs in Sleep when watchdog enabled.
// - Watchdog is cleared before entering Sleep; the registered clear pulse here comes in the first Sleep cycle.
// - Sleep disables system-clocked peripherals; external-clock ones may continue. Here every periph_clk_en bit is forced low in Sleep.
// - Sleep exits on enabled interrupt, any reset or watchdog time-out.
// - Wake from Sleep keeps the clock source active at entry.
// - Idle entry clears the watchdog; system clock stays active.
// - In Idle, RC oscillator runs if watchdog or failure monitor enabled.
// - Idle wake reapplies CPU clock at once.
// - Interrupt during power-save instruction deferred until entry completes, then wakes.
// - Slowdown divides CPU clock only; system and peripheral clocks stay full.
// - Slowdown enabled by bit 11 of clock divider register.
// - Bits 14:12 select ratio 1:1 to 1:128, default 1:1.
// - Restore-on-interrupt bit 15 makes interrupts return CPU to full speed.
// - Disable bit stops module clocks and blocks its register access. Here only the module clock enable is gated; no register access is blocked.
// - Module enabled only if bit clear and present; reset clear.
// - Disable and enable take effect one instruction cycle later.
// - New oscillator select bits 10:8 writable only when unlocked.
// - Failure monitor enabled keeps RC oscillator on except in Sleep.
module power_saving_clock_manager (
  input  wire logic                   sys_clk_i,
  input  wire logic                   rst_i,
  input  wire pwr_clk_pkg::reg_req_t  reg_req_i,
  output logic [15:0]                 reg_rdata_o,
  input  wire pwr_clk_pkg::ps_req_t   ps_req_i,
  input  wire logic                   irq_pend_i,
  input  wire logic                   watchdog_timeout_i,
  output pwr_clk_pkg::clk_ctrl_t      clk_ctrl_o,
  output pwr_clk_pkg::pm_mode_t       mode_o,
  output logic [2:0]                  cur_osc_o,
  output logic                        wake_o
);
  import pwr_clk_pkg::*;

  pm_mode_t              mode_q;
  logic [2:0]            new_osc_q;
  logic [2:0]            cur_osc_q;
  logic [15:0]           clk_div_q;
  logic [15:0]           pm_ctrl_q;
  logic [NUM_PERIPH-1:0] periph_dis_q;
  logic [NUM_PERIPH-1:0] periph_en_q;
  logic [6:0]            slow_cnt_q;
  logic                  cpu_tick;
  logic                  watchdog_clear_q;
  logic                  wake_q;
  logic                  defer_irq_q;
  logic                  irq_restore;

  // Decode a register write at a given offset
  function automatic logic reg_wr(input reg_req_t r, input logic [3:0] ofs);
    return r.wr && (r.addr == ofs);
  endfunction : reg_wr

  // Divide mask for ratio code: two to the n minus one
  function automatic logic [6:0] ratio_mask(input logic [2:0] code);
    return 7'((8'h01 << code) - 8'h01);
  endfunction : ratio_mask

  // Interrupt restore only acts while slowdown is running
  assign irq_restore = irq_pend_i && clk_div_q[RESTORE_BIT] && clk_div_q[SLOW_EN_BIT];

  // Power mode sequencing
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_q      <= MODE_RUN;
      defer_irq_q <= 1'b0;
      wake_q      <= 1'b0;
    end else begin
      wake_q <= 1'b0;
      unique case (mode_q)
        MODE_RUN: begin
          if (ps_req_i.ps_exec) begin
            mode_q      <= (ps_req_i.ps_op == PS_OP_SLEEP) ? MODE_SLEEP : MODE_IDLE;
            defer_irq_q <= irq_pend_i;
          end
        end
        MODE_SLEEP, MODE_IDLE: begin
          defer_irq_q <= 1'b0;
          if (irq_pend_i || watchdog_timeout_i || defer_irq_q) begin
            mode_q <= MODE_RUN;
            wake_q <= 1'b1;
          end
        end
        default: mode_q <= MODE_RUN;
      endcase
    end
  end

  // Watchdog clear pulse on any power-save entry while the watchdog enable bit is set
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      watchdog_clear_q <= 1'b0;
    end else begin
      watchdog_clear_q <= ps_req_i.ps_exec && (mode_q == MODE_RUN) && pm_ctrl_q[DOG_EN_BIT];
    end
  end

  // Oscillator control; the current source survives Sleep unchanged
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      new_osc_q <= OSC_SEL_RST;
      cur_osc_q <= OSC_SEL_RST;
    end else begin
      if (reg_wr(reg_req_i, OSC_CTRL_OFS) && !pm_ctrl_q[LOCK_BIT]) begin
        new_osc_q <= reg_req_i.wdata[NEW_OSC_LSB +: 3];
      end
      if (mode_q == MODE_RUN) begin
        cur_osc_q <= new_osc_q;
      end
    end
  end

  // Power manager control register
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pm_ctrl_q <= PM_CTRL_RST;
    end else if (reg_wr(reg_req_i, PM_CTRL_OFS)) begin
      pm_ctrl_q <= {13'h0000, reg_req_i.wdata[2:0]};
    end
  end

  // Clock divider register; interrupt restore clears slowdown
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      clk_div_q <= CLK_DIV_RST;
    end else begin
      if (reg_wr(reg_req_i, CLK_DIV_OFS)) begin
        clk_div_q <= {reg_req_i.wdata[15:11], 11'h000};
      end
      if (irq_restore) begin
        clk_div_q[SLOW_EN_BIT] <= 1'b0;
      end
    end
  end

  // CPU slowdown divider producing a one-cycle CPU tick
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      slow_cnt_q <= 7'h00;
    end else if (!clk_div_q[SLOW_EN_BIT] || slow_cnt_q >= ratio_mask(clk_div_q[SLOW_RAT_LSB +: 3])) begin
      slow_cnt_q <= 7'h00;
    end else begin
      slow_cnt_q <= slow_cnt_q + 7'h01;
    end
  end

  assign cpu_tick = !clk_div_q[SLOW_EN_BIT] || irq_restore || (slow_cnt_q == 7'h00);

  // Peripheral disable bits, reset clear for present peripherals
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      periph_dis_q <= '0;
    end else if (reg_wr(reg_req_i, PERIPH_DIS_OFS)) begin
      periph_dis_q <= reg_req_i.wdata[NUM_PERIPH-1:0];
    end
  end

  // Module enable follows its disable bit one CPU cycle later
  generate
    for (genvar g = 0; g < NUM_PERIPH; g++) begin : g_periph
      always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
          periph_en_q[g] <= PERIPH_PRESENT[g];
        end else if (cpu_tick) begin
          periph_en_q[g] <= !periph_dis_q[g] && PERIPH_PRESENT[g];
        end
      end
    end
  endgenerate

  // Register read data, one cycle after the read strobe
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_req_i.rd) begin
      unique case (reg_req_i.addr)
        OSC_CTRL_OFS:   reg_rdata_o <= {1'b0, cur_osc_q, 1'b0, new_osc_q, 8'h00};
        CLK_DIV_OFS:    reg_rdata_o <= clk_div_q;
        PERIPH_DIS_OFS: reg_rdata_o <= periph_dis_q;
        PM_CTRL_OFS:    reg_rdata_o <= pm_ctrl_q;
        PM_STAT_OFS:    reg_rdata_o <= {14'h0000, mode_q};
        default:        reg_rdata_o <= 16'h0000;
      endcase
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end

  // Clock and oscillator enables
  always_comb begin
    clk_ctrl_o.sys_clk_en    = (mode_q != MODE_SLEEP);
    clk_ctrl_o.sys_osc_on    = (mode_q != MODE_SLEEP);
    clk_ctrl_o.cpu_clk_en    = (mode_q == MODE_RUN) && cpu_tick;
    clk_ctrl_o.periph_clk_en = (mode_q == MODE_SLEEP) ? '0 : periph_en_q;
    clk_ctrl_o.cfm_active    = pm_ctrl_q[CFM_EN_BIT] && (mode_q != MODE_SLEEP);
    clk_ctrl_o.rc_osc_on     = (mode_q == MODE_SLEEP) ? pm_ctrl_q[DOG_EN_BIT]
                             : (pm_ctrl_q[DOG_EN_BIT] || pm_ctrl_q[CFM_EN_BIT]);
    clk_ctrl_o.watchdog_clear = watchdog_clear_q;
  end

  assign mode_o    = mode_q;
  assign cur_osc_o = cur_osc_q;
  assign wake_o    = wake_q;

endmodule : power_saving_clock_manager

// ### tb/pscm_chk_sva.sv
// Port checker for the power saving clock manager
`timescale 1ns/1ps
module pscm_chk (
  input wire logic                  sys_clk_i,
  input wire logic                  rst_i,
  input wire pwr_clk_pkg::ps_req_t  ps_req_i,
  input wire logic                  irq_pend_i,
  input wire logic                  watchdog_timeout_i,
  input wire pwr_clk_pkg::clk_ctrl_t clk_ctrl_o,
  input wire pwr_clk_pkg::pm_mode_t mode_o,
  input wire logic [2:0]            cur_osc_o,
  input wire logic                  wake_o
);
  import pwr_clk_pkg::*;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  // Mode entry, clock gating and wake relations
  property p_sleep_off;
    mode_o == MODE_SLEEP |-> !clk_ctrl_o.sys_clk_en && !clk_ctrl_o.sys_osc_on && clk_ctrl_o.periph_clk_en == '0;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("clocks running in sleep");
  property p_sleep_mon;
    mode_o == MODE_SLEEP |-> !clk_ctrl_o.cfm_active;
  endproperty
  a_sleep_mon: assert property (p_sleep_mon) else $error("monitor active in sleep");
  property p_idle_clk;
    mode_o == MODE_IDLE |-> !clk_ctrl_o.cpu_clk_en && clk_ctrl_o.sys_clk_en;
  endproperty
  a_idle_clk: assert property (p_idle_clk) else $error("wrong clocks in idle");
  property p_enter;
    ps_req_i.ps_exec && mode_o == MODE_RUN |=> mode_o == ($past(ps_req_i.ps_op) ? MODE_IDLE : MODE_SLEEP);
  endproperty
  a_enter: assert property (p_enter) else $error("mode not entered");
  property p_wake;
    mode_o != MODE_RUN && (irq_pend_i || watchdog_timeout_i) |=> mode_o == MODE_RUN && wake_o;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_defer;
    ps_req_i.ps_exec && mode_o == MODE_RUN && irq_pend_i |=> mode_o != MODE_RUN ##1 mode_o == MODE_RUN;
  endproperty
  a_defer: assert property (p_defer) else $error("coincident interrupt mishandled");
  property p_osc_hold;
    mode_o != MODE_RUN && $past(mode_o) != MODE_RUN |-> $stable(cur_osc_o);
  endproperty
  a_osc_hold: assert property (p_osc_hold) else $error("oscillator changed while asleep");
  property p_dog_clr;
    clk_ctrl_o.watchdog_clear |-> mode_o != MODE_RUN && $past(mode_o) == MODE_RUN;
  endproperty
  a_dog_clr: assert property (p_dog_clr) else $error("stray watchdog clear");
endmodule : pscm_chk

bind power_saving_clock_manager pscm_chk i_chk (.sys_clk_i, .rst_i, .ps_req_i, .irq_pend_i, .watchdog_timeout_i,
  .clk_ctrl_o, .mode_o, .cur_osc_o, .wake_o);

// ### tb/core_model.sv
// Processor core model: power-save instructions and pending interrupts
`timescale 1ns/1ps
module core_model (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_i,
  input  wire logic             save_i,
  input  wire logic             op_i,
  input  wire logic             irq_set_i,
  input  wire logic             irq_clr_i,
  output pwr_clk_pkg::ps_req_t  ps_req_o,
  output logic                  irq_pend_o
);
  import pwr_clk_pkg::*;
  logic irq_q;

  // One-cycle instruction with its operand
  assign ps_req_o = '{ps_exec: save_i, ps_op: op_i};

  // Interrupt stays pending until the handler clears it
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
    end else if (irq_set_i) begin
      irq_q <= 1'b1;
    end else if (irq_clr_i) begin
      irq_q <= 1'b0;
    end
  end
  assign irq_pend_o = irq_q | irq_set_i;
endmodule : core_model

// ### tb/power_saving_clock_manager_tb_top.sv
// Testbench for the power saving clock manager
`timescale 1ns/1ps
module power_saving_clock_manager_tb_top;
  import pwr_clk_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  reg_req_t    req = '0;
  logic        save = 1'b0;
  logic        op = 1'b0;
  logic        irq_set = 1'b0;
  logic        irq_clr = 1'b0;
  logic        dog_timeout = 1'b0;
  logic [15:0] rdata;
  ps_req_t     ps_req;
  logic        irq_pend;
  clk_ctrl_t   ctl;
  pm_mode_t    mode;
  logic [2:0]  osc;
  logic        wake;
  int          bad_count = 0;
  int          checks = 0;

  // 20 MHz clock
  always #25 clk = ~clk;

  power_saving_clock_manager i_dut (.sys_clk_i(clk), .rst_i(rst), .reg_req_i(req), .reg_rdata_o(rdata),
    .ps_req_i(ps_req), .irq_pend_i(irq_pend), .watchdog_timeout_i(dog_timeout), .clk_ctrl_o(ctl), .mode_o(mode),
    .cur_osc_o(osc), .wake_o(wake));
  core_model i_core (.sys_clk_i(clk), .rst_i(rst), .save_i(save), .op_i(op), .irq_set_i(irq_set),
    .irq_clr_i(irq_clr), .ps_req_o(ps_req), .irq_pend_o(irq_pend));

  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    req <= '{a, d, 1'b1, 1'b0};
    tick;
    req <= '0;
    tick;
  endtask : wr

  task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
    req <= '{a, 16'h0000, 1'b0, 1'b1};
    tick;
    req <= '0;
    chk(rdata, exp, "read data");
    tick;
  endtask : rdc

  task automatic end_sim;
    if (bad_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim

  // Watchdog against a hang
  initial begin
    #500000;
    bad_count++;
    end_sim();
  end

  // Test sequence
  initial begin
    logic [15:0] cnt;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    tick;
    rdc(CLK_DIV_OFS, CLK_DIV_RST);
    rdc(PERIPH_DIS_OFS, 16'h0000);
    rdc(4'hF, 16'h0000);
    chk(ctl.periph_clk_en, PERIPH_PRESENT, "periph enables");
    req <= '{PERIPH_DIS_OFS, 16'h00A5, 1'b1, 1'b0};
    tick;
    req <= '0;
    chk(ctl.periph_clk_en, 16'hFFFF, "periph enables");
    tick;
    chk(ctl.periph_clk_en, 16'hFF5A, "periph enables");
    wr(PERIPH_DIS_OFS, 16'h0000);
    chk(ctl.periph_clk_en, 16'hFFFF, "periph enables");
    wr(OSC_CTRL_OFS, 16'h0500);
    chk(osc, 3'h5, "current osc");
    wr(PM_CTRL_OFS, 16'h0007);
    wr(OSC_CTRL_OFS, 16'h0200);
    rdc(OSC_CTRL_OFS, 16'h5500);
    // Unlock so a new source can be picked while asleep
    wr(PM_CTRL_OFS, 16'h0003);
    save <= 1'b1;
    op <= PS_OP_SLEEP;
    tick;
    save <= 1'b0;
    chk({mode, ctl.watchdog_clear, ctl.rc_osc_on, ctl.cfm_active, ctl.sys_osc_on},
      {MODE_SLEEP, 4'b1100}, "sleep");
    wr(OSC_CTRL_OFS, 16'h0300);
    tick;
    dog_timeout <= 1'b1;
    tick;
    dog_timeout <= 1'b0;
    chk({wake, mode, osc}, {1'b1, MODE_RUN, 3'h5}, "sleep wake");
    save <= 1'b1;
    op <= PS_OP_IDLE;
    irq_set <= 1'b1;
    tick;
    save <= 1'b0;
    irq_set <= 1'b0;
    chk({mode, ctl.watchdog_clear, ctl.rc_osc_on, ctl.sys_clk_en, ctl.cpu_clk_en},
      {MODE_IDLE, 4'b1110}, "idle");
    tick;
    chk({wake, mode, ctl.cpu_clk_en}, {1'b1, MODE_RUN, 1'b1}, "idle wake");
    irq_clr <= 1'b1;
    tick;
    irq_clr <= 1'b0;
    // RC oscillator follows the failure monitor alone, then drops when both are off
    wr(PM_CTRL_OFS, 16'h0002);
    chk(ctl.rc_osc_on, 1'b1, "rc osc");
    wr(PM_CTRL_OFS, 16'h0000);
    chk(ctl.rc_osc_on, 1'b0, "rc osc");
    for (int n = 0; n < 8; n++) begin
      wr(CLK_DIV_OFS, 16'h0800 | (16'(n) << 12));
      cnt = '0;
      repeat (256) begin
        tick;
        cnt += ctl.cpu_clk_en;
      end
      chk(cnt, 16'h0100 >> n, "cpu ticks");
      chk(ctl.periph_clk_en & {16{ctl.sys_clk_en}}, 16'hFFFF, "periph clocks");
    end
    for (int r = 0; r < 2; r++) begin
      wr(CLK_DIV_OFS, {r[0], 3'h2, 1'b1, 11'h000});
      irq_set <= 1'b1;
      tick;
      irq_set <= 1'b0;
      irq_clr <= 1'b1;
      tick;
      irq_clr <= 1'b0;
      rdc(CLK_DIV_OFS, {r[0], 3'h2, ~r[0], 11'h000});
    end
    end_sim();
  end
endmodule : power_saving_clock_manager_tb_top
